// ### shared/umspi_pkg.sv
// constants, register map and state encoding for the master spi mode channel
package umspi_pkg;
  // register byte addresses on the apb bus
  localparam logic [11:0] ADDR_CTRL_A = 12'h000; // spi_status_ctrl_a
  localparam logic [11:0] ADDR_CTRL_B = 12'h004; // spi_status_ctrl_b
  localparam logic [11:0] ADDR_CTRL_C = 12'h008; // spi_status_ctrl_c
  localparam logic [11:0] ADDR_DATA = 12'h00c; // data_register
  localparam logic [11:0] ADDR_BAUD = 12'h010; // baud_divisor
  // spi_status_ctrl_a fields
  localparam int RXC_POS = 7; // rx_complete_flag
  localparam int TXC_POS = 6; // tx_complete_flag
  localparam int UDRE_POS = 5; // tx_buffer_empty_flag
  // spi_status_ctrl_b fields
  localparam int RXCIE_POS = 7; // rx_complete_irq_enable
  localparam int TXCIE_POS = 6; // tx_complete_irq_enable
  localparam int TX_EMPTY_IRQ_ENABLE_POS = 5; // tx_empty_irq_enable
  localparam int RXEN_POS = 4; // rx_enable_bit
  localparam int TXEN_POS = 3; // tx_enable_bit
  localparam logic [2:0] CTRL_B_RSVD = 3'h6; // reserved bits 2:0 read value
  // spi_status_ctrl_c fields
  localparam int MODE_HI_POS = 7; // mode_select_hi
  localparam int MODE_LO_POS = 6; // mode_select_lo
  localparam int ORDER_POS = 2; // bit_order_bit
  localparam int CPHA_POS = 1; // clock_phase_bit
  localparam int CPOL_POS = 0; // clock_polarity_bit
  localparam logic [1:0] MODE_MSPI = 2'h3; // master_spi_mode code
  // reset values
  localparam logic [7:0] CTRL_B_RST = 8'h06;
  localparam logic [7:0] CTRL_C_RST = 8'h06;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [7:0] TSR_IDLE = 8'hff; // line idles high
  // frame geometry
  localparam int FRAME_BITS = 8;
  localparam logic [3:0] LAST_EDGE = 4'hf; // 2*FRAME_BITS-1 clock edges
  localparam int RX_DEPTH = 2; // receive buffer words
  // shifter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } umspi_state_t;
endpackage

// ### verilog/umspi_top.sv
// master spi mode channel: apb registers, transmit buffer, shifter, receive buffer
// Function
// - transmitter enable drives serial output pin
// - receiver enable claims serial input pin
// - data write to an empty buffer starts one frame
// - buffer moves to shifter only when ready
// - overflow drops newest, keeps older bytes
// - frame, overrun, parity flags read zero
// - rx complete tracks unread data, flushed
// - tx complete on idle shifter, clearable
// - buffer empty flag, one after reset
// - rx irq needs enable, global, flag
// - tx irq needs enable, global, flag
// - empty irq needs enable, global, flag
// - receiver alone never makes clock
// - tx disable waits for empty shifter, buffer
// - mode field selects master spi
// - order bit picks lsb or msb first
// - phase bit picks sampling edge
// - polarity bit sets clock idle level
// - no slave select; mosi, miso, sck
// - spi modes 0..3 edge mapping
// - clock is pclk over 2*(divisor+1)
// - eight bits a frame, back to back
`timescale 1ns/1ns
module umspi_top
  import umspi_pkg::*;
(
  input wire logic pclk, // system clock, 100 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  input wire logic cpu_status_word_gie, // global interrupt flag
  input wire logic txc_irq_taken, // pulse: tx complete interrupt executed
  output logic irq_rx_complete, // receive complete interrupt
  output logic irq_tx_complete, // transmit complete interrupt
  output logic irq_tx_empty, // data register empty interrupt
  output logic serial_out_pin_o, // master-out data
  output logic serial_out_pin_oe_n, // low while transmitter owns the pin
  input wire logic serial_in_pin_i, // master-in data
  output logic serial_in_pin_owned, // high while receiver owns the pin
  output logic transfer_clock_pin_o, // spi clock
  output logic transfer_clock_pin_oe_n // low while transmitter owns the clock pin
);
  import umspi_pkg::*;

  // control registers
  logic [4:0] ctrl_b_r, ctrl_b_nxt; // bits 7:3 of spi_status_ctrl_b
  logic [1:0] mode_r, mode_nxt; // mode select field
  logic order_r, order_nxt; // lsb first when set
  logic cpha_r, cpha_nxt; // clock phase
  logic cpol_r, cpol_nxt; // clock polarity
  logic [11:0] baud_r, baud_nxt; // baud divisor
  // transmit path
  umspi_state_t state_r, state_nxt; // shifter state
  logic [7:0] txb_r, txb_nxt; // transmit buffer
  logic txb_full_r, txb_full_nxt; // transmit buffer holds a byte
  logic [7:0] tsr_r, tsr_nxt; // transmit shift register
  logic [7:0] rsr_r, rsr_nxt; // receive shift register
  logic [3:0] edge_r, edge_nxt; // clock edge index within a frame
  logic [11:0] cnt_r, cnt_nxt; // half period countdown
  logic xck_r, xck_nxt; // transfer clock level
  logic txc_r, txc_nxt; // tx complete flag
  logic txen_eff_r, txen_eff_nxt; // transmitter really enabled
  logic sout_r, sout_nxt; // master-out line level
  // receive buffer
  logic [7:0] rx_mem_r [0:RX_DEPTH-1]; // oldest byte at index 0
  logic [7:0] rx_mem_nxt [0:RX_DEPTH-1];
  logic [1:0] rx_cnt_r, rx_cnt_nxt; // unread bytes
  // decoded helpers
  logic wr_acc, rd_acc; // apb access phases
  logic mspi; // master spi mode selected
  logic tx_active; // transmitter may shift
  logic rxen, txen_bit; // enables from ctrl b
  logic tick; // one-cycle clock edge enable
  logic frame_done; // last edge of a frame
  logic sample_edge, setup_edge; // edge kinds
  logic rx_push; // received byte enters buffer
  logic [7:0] rx_byte; // byte completed this edge
  logic [1:0] rx_after_pop; // count once a read has popped

  // apb decode; zero wait states keep the master simple
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == ADDR_CTRL_A || paddr == ADDR_CTRL_B ||
    paddr == ADDR_CTRL_C || paddr == ADDR_DATA || paddr == ADDR_BAUD);

  assign rxen = ctrl_b_r[RXEN_POS-3];
  assign txen_bit = ctrl_b_r[TXEN_POS-3];
  assign mspi = (mode_r == MODE_MSPI);
  // receiver alone has no clock source, so only the transmitter shifts
  assign tx_active = txen_eff_r && mspi;
  assign tick = (state_r == ST_SHIFT) && (cnt_r == 12'h000);
  assign frame_done = tick && (edge_r == LAST_EDGE);
  // leading edges are even; sample there when phase is zero
  assign sample_edge = tick && (edge_r[0] == cpha_r);
  assign setup_edge = tick && (edge_r[0] != cpha_r) && (edge_r != 4'h0);
  assign rx_byte = !sample_edge ? rsr_r :
    (order_r ? {serial_in_pin_i, rsr_r[7:1]} : {rsr_r[6:0], serial_in_pin_i});
  assign rx_push = frame_done && rxen;

  // read mux; reserved bits read per register layout
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      case (paddr)
        ADDR_CTRL_A: begin
          // error flags at bits 4:2 stay zero in this mode
          prdata[RXC_POS] = (rx_cnt_r != 2'h0);
          prdata[TXC_POS] = txc_r;
          prdata[UDRE_POS] = !txb_full_r;
        end
        ADDR_CTRL_B: prdata[7:0] = {ctrl_b_r, CTRL_B_RSVD};
        ADDR_CTRL_C: prdata[7:0] = {mode_r, 3'h0, order_r, cpha_r, cpol_r};
        ADDR_DATA: prdata[7:0] = rx_mem_r[0];
        ADDR_BAUD: prdata[11:0] = baud_r;
        default: prdata = 32'h0000_0000; // unmapped reads zero with pslverr
      endcase
    end
  end

  // next-state logic for registers, shifter and buffers
  always_comb begin
    ctrl_b_nxt = ctrl_b_r;
    mode_nxt = mode_r;
    order_nxt = order_r;
    cpha_nxt = cpha_r;
    cpol_nxt = cpol_r;
    baud_nxt = baud_r;
    state_nxt = state_r;
    txb_nxt = txb_r;
    txb_full_nxt = txb_full_r;
    tsr_nxt = tsr_r;
    rsr_nxt = rsr_r;
    edge_nxt = edge_r;
    cnt_nxt = cnt_r;
    xck_nxt = xck_r;
    txc_nxt = txc_r;
    txen_eff_nxt = txen_eff_r;
    rx_mem_nxt = rx_mem_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_after_pop = rx_cnt_r;
    // configuration writes; reserved bits are expected as zero and dropped
    if (wr_acc) begin
      case (paddr)
        ADDR_CTRL_B: ctrl_b_nxt = pwdata[7:3];
        ADDR_CTRL_C: begin
          // mode and frame format may change in one write
          mode_nxt = pwdata[MODE_HI_POS:MODE_LO_POS];
          order_nxt = pwdata[ORDER_POS];
          cpha_nxt = pwdata[CPHA_POS];
          cpol_nxt = pwdata[CPOL_POS];
        end
        ADDR_BAUD: baud_nxt = pwdata[11:0];
        default: ;
      endcase
    end
    // shifter
    case (state_r)
      ST_IDLE: begin
        xck_nxt = cpol_r;
        if (txb_full_r && tx_active) begin
          tsr_nxt = txb_r;
          txb_full_nxt = 1'b0;
          state_nxt = ST_SHIFT;
          cnt_nxt = baud_r;
          edge_nxt = 4'h0;
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          cnt_nxt = baud_r; // half period of baud+1 cycles
          xck_nxt = !xck_r;
          edge_nxt = edge_r + 4'h1;
          if (sample_edge) begin
            rsr_nxt = rx_byte;
          end
          if (setup_edge) begin
            // vacated bits fill with ones so the line idles high
            tsr_nxt = order_r ? {1'b1, tsr_r[7:1]} : {tsr_r[6:0], 1'b1};
          end
          if (frame_done) begin
            if (txb_full_r && tx_active) begin
              // next byte follows with no gap
              tsr_nxt = txb_r;
              txb_full_nxt = 1'b0;
              edge_nxt = 4'h0;
            end else begin
              tsr_nxt = TSR_IDLE;
              state_nxt = ST_IDLE;
              xck_nxt = cpol_r;
            end
          end
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        xck_nxt = cpol_r;
      end
    endcase
    // the line holds through a sample edge so the far side never sees it move there
    sout_nxt = sample_edge ? sout_r : (order_r ? tsr_nxt[0] : tsr_nxt[7]);
    // a data write fills the empty buffer; reads never start a frame
    if (wr_acc && paddr == ADDR_DATA && !txb_full_r && tx_active) begin
      txb_nxt = pwdata[7:0];
      txb_full_nxt = 1'b1;
    end
    // tx complete: clear by write-one or interrupt taken, set wins
    if ((wr_acc && paddr == ADDR_CTRL_A && pwdata[TXC_POS]) || txc_irq_taken) begin
      txc_nxt = 1'b0;
    end
    if (frame_done && !txb_full_r) begin
      txc_nxt = 1'b1;
    end
    // disabling waits until shifter and buffer are both empty
    if (txen_bit) begin
      txen_eff_nxt = 1'b1;
    end else if (state_r == ST_IDLE && !txb_full_r) begin
      txen_eff_nxt = 1'b0;
    end
    // receive buffer: pop on data read, then push
    if (rd_acc && paddr == ADDR_DATA && rx_cnt_r != 2'h0) begin
      rx_mem_nxt[0] = rx_mem_r[1];
      rx_after_pop = rx_cnt_r - 2'h1;
    end
    rx_cnt_nxt = rx_after_pop;
    // a full buffer drops the newest byte and keeps the older ones
    if (rx_push && rx_after_pop != 2'(RX_DEPTH)) begin
      rx_mem_nxt[rx_after_pop[0]] = rx_byte;
      rx_cnt_nxt = rx_after_pop + 2'h1;
    end
    // disabling the receiver flushes the buffer
    if (!rxen) begin
      rx_cnt_nxt = 2'h0;
    end
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_r <= CTRL_B_RST[7:3];
      mode_r <= CTRL_C_RST[MODE_HI_POS:MODE_LO_POS];
      order_r <= CTRL_C_RST[ORDER_POS];
      cpha_r <= CTRL_C_RST[CPHA_POS];
      cpol_r <= CTRL_C_RST[CPOL_POS];
      baud_r <= BAUD_RST;
      state_r <= ST_IDLE;
      txb_r <= 8'h00;
      txb_full_r <= 1'b0;
      tsr_r <= TSR_IDLE;
      sout_r <= TSR_IDLE[0];
      rsr_r <= 8'h00;
      edge_r <= 4'h0;
      cnt_r <= 12'h000;
      xck_r <= CTRL_C_RST[CPOL_POS];
      txc_r <= 1'b0;
      txen_eff_r <= 1'b0;
      rx_mem_r[0] <= 8'h00;
      rx_mem_r[1] <= 8'h00;
      rx_cnt_r <= 2'h0;
    end else begin
      ctrl_b_r <= ctrl_b_nxt;
      mode_r <= mode_nxt;
      order_r <= order_nxt;
      cpha_r <= cpha_nxt;
      cpol_r <= cpol_nxt;
      baud_r <= baud_nxt;
      state_r <= state_nxt;
      txb_r <= txb_nxt;
      txb_full_r <= txb_full_nxt;
      tsr_r <= tsr_nxt;
      sout_r <= sout_nxt;
      rsr_r <= rsr_nxt;
      edge_r <= edge_nxt;
      cnt_r <= cnt_nxt;
      xck_r <= xck_nxt;
      txc_r <= txc_nxt;
      txen_eff_r <= txen_eff_nxt;
      rx_mem_r <= rx_mem_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // pins: no slave select exists, the far device is selected externally
  assign serial_out_pin_o = sout_r;
  assign serial_out_pin_oe_n = !txen_eff_r;
  assign transfer_clock_pin_o = xck_r;
  assign transfer_clock_pin_oe_n = !txen_eff_r;
  assign serial_in_pin_owned = rxen;
  // interrupt requests are plain levels qualified by the global flag
  assign irq_rx_complete = ctrl_b_r[RXCIE_POS-3] && cpu_status_word_gie && (rx_cnt_r != 2'h0);
  assign irq_tx_complete = ctrl_b_r[TXCIE_POS-3] && cpu_status_word_gie && txc_r;
  assign irq_tx_empty = ctrl_b_r[TX_EMPTY_IRQ_ENABLE_POS-3] && cpu_status_word_gie && !txb_full_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // helper: clock toggles counted inside one frame
  logic [4:0] tog_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_cnt_r <= 5'h00;
    end else if (state_r == ST_IDLE || frame_done) begin
      tog_cnt_r <= 5'h00;
    end else if (tick) begin
      tog_cnt_r <= tog_cnt_r + 5'h01;
    end
  end

  sequence data_write_s;
    wr_acc && paddr == ADDR_DATA && !txb_full_r && tx_active;
  endsequence
  sequence frame_starts_s;
    state_r == ST_SHIFT && !txb_full_r;
  endsequence
  sequence idle_load_s;
    state_r == ST_IDLE && txb_full_r && tx_active;
  endsequence

  write_starts_a: assert property (data_write_s |=> txb_full_r ##1 state_r == ST_SHIFT)
    else $error("data write did not start a frame");
  load_moves_a: assert property (idle_load_s |=> frame_starts_s)
    else $error("buffered byte not moved into idle shifter");
  err_flags_zero_a: assert property (rd_acc && paddr == ADDR_CTRL_A |-> prdata[4:0] == 5'h00)
    else $error("error flags not zero");
  frame_len_a: assert property (frame_done |-> tog_cnt_r == 5'h0f)
    else $error("frame does not have sixteen clock edges");
  idle_clock_a: assert property (state_r == ST_IDLE |=> state_r == ST_SHIFT || xck_r == $past(cpol_r))
    else $error("clock not idle at polarity level");
  txc_set_a: assert property (frame_done && !txb_full_r |=> txc_r)
    else $error("tx complete not set after last frame");
  rx_flush_a: assert property (!rxen |=> rx_cnt_r == 2'h0 && !irq_rx_complete)
    else $error("receive buffer not flushed");
  txen_hold_a: assert property (txen_eff_r && (state_r != ST_IDLE || txb_full_r) |=> txen_eff_r)
    else $error("transmitter released while busy");
  overflow_keep_a: assert property (rx_push && rx_cnt_r == 2'h2 && !rd_acc |=>
    rx_mem_r[0] == $past(rx_mem_r[0]) && rx_mem_r[1] == $past(rx_mem_r[1]) && rx_cnt_r == 2'h2)
    else $error("overflow overwrote older byte");
  half_period_a: assert property (tick && !frame_done |=> cnt_r == $past(baud_r) && state_r == ST_SHIFT)
    else $error("half period not reloaded from divisor");
  empty_irq_a: assert property (irq_tx_empty |-> cpu_status_word_gie && !txb_full_r)
    else $error("empty interrupt without its cause");
endmodule

// ### testbench/umspi_slave_model.sv
// spi slave device model on the far side of the master spi channel
`timescale 1ns/1ns
module umspi_slave_model (
  input wire logic sck, // spi clock from the master
  input wire logic mosi, // master-out data
  output logic miso, // master-in data
  input wire logic cpol, // clock idle level
  input wire logic cpha, // sample on trailing edge when set
  input wire logic lsb // lsb first when set
);
  logic [7:0] tx_q[$]; // reply bytes queued by the bench
  logic [7:0] rx_q[$]; // bytes seen on mosi
  logic [7:0] tx_b = 8'hff; // reply byte being shifted
  logic [7:0] rx_b = 8'h00; // byte being assembled
  logic primed = 1'b0; // a reply byte is loaded
  int edge_n = 0; // clock edges seen in this frame
  initial miso = 1'b1;
  function automatic int idx(input int k);
    return lsb ? k : 7 - k;
  endfunction
  // forget a partial count after the idle level moved
  task automatic clear();
    edge_n = 0;
  endtask
  // a released line shows no stale bit, so it is inverted
  task automatic load();
    primed = (tx_q.size() > 0);
    if (!primed) miso = ~miso;
    else begin
      tx_b = tx_q.pop_front();
      miso = cpha ? ~miso : tx_b[idx(0)];
    end
  endtask
  // sample and setup on opposite edges; no select line exists
  always @(sck) begin
    if ((sck != cpol) ^ cpha) rx_b[idx(edge_n / 2)] = mosi;
    else if (edge_n < 15) miso = tx_b[idx((edge_n + 1) / 2)];
    edge_n++;
    if (edge_n == 16) begin
      edge_n = 0;
      rx_q.push_back(rx_b);
      load();
    end
  end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the master spi channel with a queue model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  import umspi_pkg::*;
  logic pclk = 1'b0; // system clock
  logic presetn = 1'b0; // reset, active low
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready, pslverr; // apb answer
  logic gie = 1'b0; // global interrupt flag
  logic irq_taken = 1'b0; // interrupt executed pulse
  logic irq_rxc, irq_txc, irq_txe; // interrupt lines
  logic mosi, mosi_oe_n, miso, miso_own, sck, sck_oe_n; // serial pins
  logic [7:0] ctrl_c = 8'h06; // bench copy of format bits
  logic [11:0] baud = 12'h000; // bench copy of divisor
  logic [31:0] rd; // last read data
  logic err; // last error answer
  logic [7:0] exp_rx[$]; // bytes the receive buffer must hold
  logic [7:0] exp_tx[$]; // bytes the slave must see
  logic [11:0] rst_a[4] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CTRL_C, ADDR_BAUD};
  logic [31:0] rst_v[4] = '{32'h20, 32'h06, 32'h06, 32'h00};
  int err_count = 0;
  int checked = 0;
  int seed = 53;
  int half = 0; // pclk cycles since the last clock toggle
  logic sck_d = 1'b0;
  logic cpol_q = 1'b0; // idle level the design has had a cycle to adopt
  umspi_top umspi_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_status_word_gie(gie), .txc_irq_taken(irq_taken), .irq_rx_complete(irq_rxc),
    .irq_tx_complete(irq_txc), .irq_tx_empty(irq_txe), .serial_out_pin_o(mosi), .serial_out_pin_oe_n(mosi_oe_n),
    .serial_in_pin_i(miso), .serial_in_pin_owned(miso_own), .transfer_clock_pin_o(sck),
    .transfer_clock_pin_oe_n(sck_oe_n));
  umspi_slave_model slave_model_inst (.sck(sck), .mosi(mosi), .miso(miso), .cpol(ctrl_c[CPOL_POS]),
    .cpha(ctrl_c[CPHA_POS]), .lsb(ctrl_c[ORDER_POS]));
  always #5 pclk = ~pclk;
  // half period and idle level; the first toggle of a frame has its own lead-in
  // sampled on the falling edge, where the pin is settled; a new polarity shows a cycle late
  always @(negedge pclk) begin
    half = half + 1;
    if (sck !== sck_d) begin
      if (slave_model_inst.edge_n != 1) `CHK("half period", baud + 12'h001, 12'(half))
      half = 0;
    end else if (half > 2 && slave_model_inst.edge_n == 0) `CHK("clock idle", cpol_q, sck)
    sck_d = sck;
    cpol_q = ctrl_c[CPOL_POS];
  end
  task automatic end_sim();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      end_sim();
    end
  endtask
  // bounded poll of one status bit
  task automatic poll(input logic [11:0] a, input int pos, input logic v);
    int n;
    n = 0;
    do begin
      xfer(a, 1'b0, 32'h0);
      n++;
    end while (rd[pos] !== v && n < 400);
    if (rd[pos] !== v) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic cfg(input logic [7:0] c, input logic [11:0] bd, input logic [7:0] b);
    xfer(ADDR_CTRL_C, 1'b1, {24'h0, c});
    ctrl_c = c;
    xfer(ADDR_CTRL_B, 1'b1, {24'h0, b});
    xfer(ADDR_BAUD, 1'b1, {20'h0, bd});
    baud = bd;
    xfer(ADDR_CTRL_B, 1'b0, 32'h0);
    `CHK("ctrl_b readback", {24'h0, b | 8'h06}, rd)
    repeat (2) @(posedge pclk);
    slave_model_inst.clear();
  endtask
  // model: every written byte is shifted; a third unread reply is dropped
  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    r = 8'($random(seed));
    poll(ADDR_CTRL_A, UDRE_POS, 1'b1);
    exp_tx.push_back(b);
    if (exp_rx.size() < 2) exp_rx.push_back(r);
    slave_model_inst.tx_q.push_back(r);
    if (!slave_model_inst.primed) slave_model_inst.load();
    xfer(ADDR_DATA, 1'b1, {24'h0, b});
  endtask
  task automatic drain();
    poll(ADDR_CTRL_A, TXC_POS, 1'b1);
    `CHK("unused flags", 5'h00, rd[4:0])
    `CHK("frame count", exp_tx.size(), slave_model_inst.rx_q.size())
    while (exp_tx.size() > 0 && slave_model_inst.rx_q.size() > 0) `CHK("mosi byte", exp_tx.pop_front(), slave_model_inst.rx_q.pop_front())
    while (exp_rx.size() > 0) begin
      xfer(ADDR_DATA, 1'b0, 32'h0);
      `CHK("rx byte", {24'h0, exp_rx.pop_front()}, rd)
    end
    xfer(ADDR_CTRL_A, 1'b1, 32'h40);
    xfer(ADDR_CTRL_A, 1'b0, 32'h0);
    `CHK("flags after drain", 2'b00, {rd[RXC_POS], rd[TXC_POS]})
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(rst_a[i], 1'b0, 32'h0);
      `CHK("reset value", rst_v[i], rd)
    end
    xfer(12'h020, 1'b0, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    // wrong mode, then receiver alone: a data write must start nothing
    for (int i = 0; i < 2; i++) begin
      cfg(i ? 8'hc6 : 8'h06, 12'h000, i ? 8'h10 : 8'h18);
      xfer(ADDR_DATA, 1'b1, 32'h5a);
      repeat (40) @(posedge pclk);
      xfer(ADDR_CTRL_A, 1'b0, 32'h0);
      `CHK("no frame status", 32'h20, rd)
      `CHK("no frame seen", 0, slave_model_inst.rx_q.size())
    end
    `CHK("rx only pins", 2'b11, {mosi_oe_n, miso_own})
    // every polarity, phase and order, with several divisors
    for (int m = 0; m < 8; m++) begin
      cfg(8'hc0 | 8'(m), 12'(m % 3), 8'h18);
      `CHK("pins owned", 2'b01, {mosi_oe_n, miso_own})
      send(8'($random(seed)));
      drain();
    end
    // three frames back to back with no reads: the newest reply is lost
    cfg(8'hc0, 12'h001, 8'h18);
    repeat (3) send(8'($random(seed)));
    drain();
    // transmitter disable waits for the buffered byte and the shifter
    cfg(8'hc4, 12'h002, 8'h18);
    send(8'($random(seed)));
    send(8'($random(seed)));
    xfer(ADDR_CTRL_B, 1'b1, 32'h10);
    `CHK("tx held while busy", 1'b0, mosi_oe_n)
    drain();
    `CHK("tx released", 2'b11, {mosi_oe_n, sck_oe_n})
    // interrupts gated by enable and global flag, then flush on rx disable
    cfg(8'hc0, 12'h000, 8'hf8);
    `CHK("irq gated", 3'b000, {irq_rxc, irq_txc, irq_txe})
    gie <= 1'b1;
    send(8'($random(seed)));
    poll(ADDR_CTRL_A, TXC_POS, 1'b1);
    `CHK("irq all", 3'b111, {irq_rxc, irq_txc, irq_txe})
    irq_taken <= 1'b1;
    @(posedge pclk);
    irq_taken <= 1'b0;
    @(posedge pclk);
    `CHK("irq taken", 3'b101, {irq_rxc, irq_txc, irq_txe})
    xfer(ADDR_CTRL_B, 1'b1, 32'he8);
    xfer(ADDR_CTRL_A, 1'b0, 32'h0);
    `CHK("rx flushed", 2'b00, {rd[RXC_POS], irq_rxc})
    `CHK("mosi byte", exp_tx.pop_front(), slave_model_inst.rx_q.pop_front())
    end_sim();
  end
endmodule
